// file: hw/pfbo_pkg.sv
package pfbo_pkg;

  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int ADDR_W = 22;               // address_bus width
  localparam int DATA_W = 8;                // data_bus width

  // ***************************************************************
  // timing at 20 MHz (50 ns period)
  // ***************************************************************
  localparam int CLK_NS        = 50;
  localparam int STROBE_NS     = 120;       // low time of a read or write strobe
  localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_NS      = 500;       // low time of the device reset pin
  localparam int RESET_CYC     = (RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_NS    = 100;       // wait after reset release before access
  localparam int RECOVER_CYC   = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W         = 8;

  // ***************************************************************
  // address bits for protect / unprotect selection
  // ***************************************************************
  localparam int PROT_A6 = 6;
  localparam int PROT_A1 = 1;
  localparam int PROT_A0 = 0;

  // ***************************************************************
  // host request kinds
  // ***************************************************************
  typedef enum logic [2:0]
  {
    PFBO_OP_READ      = 3'h0,
    PFBO_OP_WRITE     = 3'h1,
    PFBO_OP_RESET     = 3'h2,
    PFBO_OP_PROTECT   = 3'h3,
    PFBO_OP_UNPROTECT = 3'h4
  } pfbo_op_e;

  // ***************************************************************
  // sequencer states, gray along idle -> setup -> strobe -> hold
  // ***************************************************************
  typedef enum logic [2:0]
  {
    PFBO_ST_IDLE    = 3'b000,
    PFBO_ST_SETUP   = 3'b001,
    PFBO_ST_STROBE  = 3'b011,
    PFBO_ST_HOLD    = 3'b010,
    PFBO_ST_RSTLOW  = 3'b110,
    PFBO_ST_RECOVER = 3'b111
  } pfbo_state_e;

endpackage

// file: hw/pfbo_sync.sv
`timescale 1ns/100ps
`default_nettype none
// three-stage input filter: output changes once stages two and three agree
module pfbo_sync
(
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic din,
  output var  logic dout
);

  logic [2:0] stage_reg;   // stage_reg[0] is read only by stage_reg[1]
  logic       dout_reg;    // filtered level

  // shift chain, reset to idle-high (pins here idle high)
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      stage_reg <= 3'h7;
    else
      stage_reg <= {stage_reg[1:0], din};
  end

  // accept a new level only when stages two and three agree
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      dout_reg <= 1'b1;
    else if (stage_reg[1] == stage_reg[2])
      dout_reg <= stage_reg[2];
  end

  assign dout = dout_reg;

endmodule
`default_nettype wire

// file: hw/pfbo_host.sv
`timescale 1ns/100ps
`default_nettype none
// host-side sequencer that drives the flash pins
module pfbo_host
(
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  // user request port
  input  wire logic                          req_valid,
  input  wire pfbo_pkg::pfbo_op_e            req_op,
  input  wire logic [pfbo_pkg::ADDR_W-1:0]   req_addr,
  input  wire logic [pfbo_pkg::DATA_W-1:0]   req_wdata,
  input  wire logic                          boost_en,
  output logic                               req_ready,
  output logic                               rsp_valid,
  output logic [pfbo_pkg::DATA_W-1:0]        rsp_rdata,
  output logic                               flash_busy,
  // flash pins
  output logic                               chip_sel_n,
  output logic                               out_en_n,
  output logic                               write_en_n,
  output logic                               reset_n,
  output logic                               reset_hv,
  output logic                               program_boost_pin,
  output logic [pfbo_pkg::ADDR_W-1:0]        address_bus,
  input  wire logic [pfbo_pkg::DATA_W-1:0]   data_bus_i,
  output logic [pfbo_pkg::DATA_W-1:0]        data_bus_o,
  output logic                               data_bus_oe,
  input  wire logic                          ready_busy_n
);
  import pfbo_pkg::*;

  // ***************************************************************
  // registers
  // ***************************************************************
  pfbo_state_e          state_reg, state_next;  // sequencer state
  pfbo_op_e             op_reg;                 // operation in flight
  logic [CNT_W-1:0]     cnt_reg;                // cycle counter
  logic                 ce_n_reg, oe_n_reg, we_n_reg;
  logic                 rst_n_reg, rst_hv_reg, boost_reg;
  logic [ADDR_W-1:0]    addr_reg;
  logic [DATA_W-1:0]    wdata_reg, rdata_reg;
  logic                 doe_reg;                // host drives data_bus
  logic                 rsp_reg;
  logic                 rdy_busy_s;             // filtered ready_busy_n

  // busy pin comes from another domain, so filter it
  pfbo_sync u_rb_sync
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (ready_busy_n),
    .dout    (rdy_busy_s)
  );

  // ***************************************************************
  // decode
  // ***************************************************************
  wire take      = (state_reg == PFBO_ST_IDLE) & req_valid;
  // on the take edge op_reg still holds the previous op; decode the incoming one
  // there, or the high-voltage flag and data drive would follow a stale request
  pfbo_op_e             op_cur;
  assign op_cur  = take ? req_op : op_reg;
  wire is_read   = (op_cur == PFBO_OP_READ);
  wire is_prot   = (op_cur == PFBO_OP_PROTECT);
  wire is_unprot = (op_cur == PFBO_OP_UNPROTECT);
  wire is_hv     = is_prot | is_unprot;
  wire cnt_done  = (cnt_reg == '0);

  // build protect / unprotect address pattern on the low bits
  function automatic logic [ADDR_W-1:0] prot_addr(input logic [ADDR_W-1:0] a,
                                                  input logic unprot);
    logic [ADDR_W-1:0] r;
    r          = a;
    r[PROT_A6] = unprot;
    r[PROT_A1] = 1'b1;
    r[PROT_A0] = 1'b0;
    return r;
  endfunction

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PFBO_ST_IDLE:
        if (req_valid)
          state_next = (req_op == PFBO_OP_RESET) ? PFBO_ST_RSTLOW : PFBO_ST_SETUP;
      PFBO_ST_SETUP:
        state_next = PFBO_ST_STROBE;
      PFBO_ST_STROBE:
        if (cnt_done)
          state_next = PFBO_ST_HOLD;
      PFBO_ST_HOLD:
        state_next = PFBO_ST_IDLE;
      PFBO_ST_RSTLOW:
        if (cnt_done)
          state_next = PFBO_ST_RECOVER;
      PFBO_ST_RECOVER:
        if (cnt_done)
          state_next = PFBO_ST_IDLE;
      default:
        state_next = PFBO_ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      state_reg <= PFBO_ST_IDLE;
    else
      state_reg <= state_next;
  end

  // latch request fields on acceptance
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      op_reg    <= PFBO_OP_READ;
      addr_reg  <= '0;
      wdata_reg <= '0;
    end
    else if (take)
    begin
      op_reg    <= req_op;
      addr_reg  <= (req_op == PFBO_OP_PROTECT || req_op == PFBO_OP_UNPROTECT) ?
                   prot_addr(req_addr, req_op == PFBO_OP_UNPROTECT) : req_addr;
      wdata_reg <= req_wdata;
    end
  end

  // cycle counter: loaded on entry to timed states
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      cnt_reg <= '0;
    else if (take && req_op == PFBO_OP_RESET)
      cnt_reg <= CNT_W'(RESET_CYC - 1);
    else if (state_reg == PFBO_ST_SETUP)
      cnt_reg <= CNT_W'(STROBE_CYC - 1);
    else if (state_reg == PFBO_ST_RSTLOW && cnt_done)
      cnt_reg <= CNT_W'(RECOVER_CYC - 1);
    else if (!cnt_done)
      cnt_reg <= cnt_reg - 1'b1;
  end

  // ***************************************************************
  // pin drive
  // ***************************************************************
  wire strobe_nx = (state_next == PFBO_ST_STROBE);
  wire sel_nx    = (state_next == PFBO_ST_SETUP) | strobe_nx | (state_next == PFBO_ST_HOLD);

  // control strobes; idle leaves chip deselected
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
    end
    else
    begin
      ce_n_reg <= ~sel_nx;
      oe_n_reg <= ~(strobe_nx & is_read);
      we_n_reg <= ~(strobe_nx & ~is_read);
    end
  end

  // reset pin: low for the pulse, high-voltage flag for protect modes
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rst_n_reg  <= 1'b0;
      rst_hv_reg <= 1'b0;
    end
    else
    begin
      rst_n_reg  <= (state_next != PFBO_ST_RSTLOW);
      rst_hv_reg <= sel_nx & is_hv & (state_next != PFBO_ST_RSTLOW);
    end
  end

  // boost pin follows user enable; unlock-bypass two-write pairs are user-sequenced
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      boost_reg <= 1'b0;
    else
      boost_reg <= boost_en;
  end

  // data bus drive only while writing and output enable high
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      doe_reg <= 1'b0;
    else
      doe_reg <= sel_nx & ~is_read & (state_next != PFBO_ST_RSTLOW);
  end

  // capture read data at the end of the strobe
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rdata_reg <= '0;
      rsp_reg   <= 1'b0;
    end
    else
    begin
      rsp_reg <= (state_reg == PFBO_ST_STROBE) & cnt_done & is_read;
      if ((state_reg == PFBO_ST_STROBE) && cnt_done && is_read)
        rdata_reg <= data_bus_i;
    end
  end

  // ready goes low on acceptance; registered for flop-driven output
  logic rdy_reg;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rdy_reg <= 1'b0;
    else
      rdy_reg <= (state_next == PFBO_ST_IDLE);
  end

  // busy level, filtered; inverted so 1 means busy
  logic busy_reg;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      busy_reg <= 1'b0;
    else
      busy_reg <= ~rdy_busy_s;
  end

  assign req_ready         = rdy_reg;
  assign rsp_valid         = rsp_reg;
  assign rsp_rdata         = rdata_reg;
  assign flash_busy        = busy_reg;
  assign chip_sel_n        = ce_n_reg;
  assign out_en_n          = oe_n_reg;
  assign write_en_n        = we_n_reg;
  assign reset_n           = rst_n_reg;
  assign reset_hv          = rst_hv_reg;
  assign program_boost_pin = boost_reg;
  assign address_bus       = addr_reg;
  assign data_bus_o        = wdata_reg;
  assign data_bus_oe       = doe_reg;

endmodule
`default_nettype wire

// file: dv/pfbo_host_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************************************
// pin-level checks on the host sequencer, one clock domain
// ***************************************************************
module pfbo_host_sva
  import pfbo_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic              chip_sel_n,
  input wire logic              out_en_n,
  input wire logic              write_en_n,
  input wire logic              reset_n,
  input wire logic              reset_hv,
  input wire logic [ADDR_W-1:0] address_bus,
  input wire logic              data_bus_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_read_levels:
    assert property (!out_en_n |-> write_en_n && !chip_sel_n) else $error("read strobe misframed");
  a_write_levels:
    assert property (!write_en_n |-> out_en_n && !chip_sel_n) else $error("write strobe misframed");
  a_read_width:
    assert property ($fell(out_en_n) |-> !out_en_n [*3] ##1 out_en_n) else $error("read strobe width");
  a_write_width:
    assert property ($fell(write_en_n) |-> !write_en_n [*3] ##1 write_en_n)
    else $error("write strobe width");
  a_read_answer:
    assert property ($rose(out_en_n) |-> rsp_valid) else $error("read data not returned");
  a_protect_bits:
    assert property (reset_hv |-> out_en_n && address_bus[PROT_A1]
      && !address_bus[PROT_A0]) else $error("protect address bits wrong");
  a_drive_safe:
    assert property (data_bus_oe |-> out_en_n && !chip_sel_n) else $error("data driven on a read");
  a_idle_quiet:
    assert property (req_ready |-> chip_sel_n && !data_bus_oe) else $error("bus active while idle");
  a_reset_pulse:
    assert property ($fell(reset_n) |-> !reset_n [*8]) else $error("device reset pulse short");
endmodule

bind pfbo_host pfbo_host_sva pfbo_host_sva_i
(
  .clk_sys(clk_sys), .reset(reset), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n), .reset_n(reset_n),
  .reset_hv(reset_hv), .address_bus(address_bus), .data_bus_oe(data_bus_oe)
);
`default_nettype wire

// file: dv/pfbo_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************************************
// behavioural flash: 16 bytes decoded from the low address bits
// ***************************************************************
module pfbo_flash_model
(
  input  wire logic        chip_sel_n,
  input  wire logic        out_en_n,
  input  wire logic        write_en_n,
  input  wire logic        reset_n,
  input  wire logic        reset_hv,
  input  wire logic        program_boost_pin,
  input  wire logic [21:0] address_bus,
  input  wire logic [7:0]  data_bus_o,
  input  wire logic        data_bus_oe,
  output logic [7:0]       data_bus_i,
  output logic             ready_busy_n
);
  logic [7:0]  mem [0:15];  // array contents, reads need no command
  logic [7:0]  last_q;      // last byte driven, inverted once released
  logic [29:0] cmd_q;       // latched command address and data
  // reads only with select, output enable and no reset; never the command latch
  wire drive = !chip_sel_n && !out_en_n && write_en_n && reset_n;
  initial
  begin
    for (int i = 0; i < 16; i++) mem[i] = 8'h30 + 8'(i);
    ready_busy_n = 1'b1;
    last_q = 8'h00;
    cmd_q = '0;
  end
  always @* if (drive) last_q = mem[address_bus[3:0]];
  // a released bus shows no stale byte, so a late sample cannot pass
  assign data_bus_i = drive ? mem[address_bus[3:0]] : ~last_q;
  // write latched at the rising strobe; protect cycles do not program
  always @(posedge write_en_n)
    if (!chip_sel_n && out_en_n && reset_n && data_bus_oe && !reset_hv)
    begin
      cmd_q = {address_bus, data_bus_o};
      mem[address_bus[3:0]] = data_bus_o;
      ready_busy_n = 1'b0;
      #(program_boost_pin ? 100 : 200) ready_busy_n = 1'b1;
    end
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pfbo_pkg::*;
  // ***************************************************************
  // stimulus, observation and bookkeeping
  // ***************************************************************
  logic              clk_sys = 1'b0;
  logic              reset, req_valid, boost_en, whv;
  pfbo_op_e          req_op;
  logic [ADDR_W-1:0] req_addr, address_bus, wa;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, data_bus_o, data_bus_i, got;
  logic              req_ready, rsp_valid, flash_busy, chip_sel_n, out_en_n, write_en_n;
  logic              reset_n, reset_hv, program_boost_pin, data_bus_oe, ready_busy_n;
  int                miscompares = 0, check_count = 0, rlow, busy_seen;

  always #25 clk_sys = ~clk_sys;

  pfbo_host pfbo_host_i
  (
    .clk_sys(clk_sys), .reset(reset), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_wdata(req_wdata), .boost_en(boost_en), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .flash_busy(flash_busy),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n), .reset_n(reset_n),
    .reset_hv(reset_hv), .program_boost_pin(program_boost_pin), .address_bus(address_bus),
    .data_bus_i(data_bus_i), .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe),
    .ready_busy_n(ready_busy_n)
  );
  pfbo_flash_model pfbo_flash_model_i
  (
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n), .reset_n(reset_n),
    .reset_hv(reset_hv), .program_boost_pin(program_boost_pin), .address_bus(address_bus),
    .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe), .data_bus_i(data_bus_i),
    .ready_busy_n(ready_busy_n)
  );

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  // one request: launched at a rising edge, watched at falling edges until idle
  task automatic do_op(input pfbo_op_e op, input logic [21:0] a, input logic [7:0] d);
    int n;
    n = 0;
    {got, wa, whv, rlow, busy_seen} = 'x;
    {rlow, busy_seen} = '0;
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && n < 100) @(negedge clk_sys);
    @(posedge clk_sys);
    {req_valid, req_op, req_addr, req_wdata} <= {1'b1, op, a, d};
    @(posedge clk_sys);
    req_valid <= 1'b0;
    do
    begin
      @(negedge clk_sys);
      n++;
      if (rsp_valid === 1'b1) got = rsp_rdata;
      if (write_en_n === 1'b0) {wa, whv} = {address_bus, reset_hv};
      if (reset_n === 1'b0) rlow++;
      if (flash_busy === 1'b1) busy_seen++;
    end
    while (req_ready !== 1'b1 && n < 40);
    chk(n < 40, "request never completed");
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_idle;
    repeat (3) @(negedge clk_sys);
    chk(chip_sel_n === 1'b1 && data_bus_oe === 1'b0, "bus not idle");
    chk(reset_n === 1'b1 && req_ready === 1'b1, "not ready after reset");
    $display("test idle done");
  endtask

  // back-to-back reads straight after reset, no command first
  task automatic t_read_array;
    for (int i = 0; i < 4; i++)
    begin
      do_op(PFBO_OP_READ, 22'h100000 | 22'(i), 8'h00);
      chk(got === 8'h30 + 8'(i), "array read wrong");
    end
    $display("test read array done");
  endtask

  task automatic t_write_read;
    do_op(PFBO_OP_WRITE, 22'h000005, 8'hc3);
    do_op(PFBO_OP_READ, 22'h2a0005, 8'h00);
    chk(got === 8'hc3, "written byte lost");
    do_op(PFBO_OP_READ, 22'h000006, 8'h00);
    chk(got === 8'h36, "neighbour disturbed");
    $display("test write read done");
  endtask

  task automatic t_bypass;
    do_op(PFBO_OP_WRITE, 22'h000555, 8'ha0);
    do_op(PFBO_OP_WRITE, 22'h000009, 8'h7e);
    chk(wa === 22'h000009, "program address wrong");
    do_op(PFBO_OP_READ, 22'h000009, 8'h00);
    chk(got === 8'h7e, "two-write program failed");
    $display("test bypass done");
  endtask

  // bits 6, 1 and 0 forced against what the request carried
  task automatic t_protect;
    do_op(PFBO_OP_PROTECT, 22'h3fffff, 8'h00);
    chk(whv === 1'b1 && wa[6:0] === 7'b0111110, "protect cycle wrong");
    do_op(PFBO_OP_UNPROTECT, 22'h000000, 8'h00);
    chk(whv === 1'b1 && wa[6:0] === 7'b1000010, "unprotect cycle wrong");
    $display("test protect done");
  endtask

  // device reset right behind a program, while the device reports busy
  task automatic t_reset_busy;
    do_op(PFBO_OP_WRITE, 22'h00000c, 8'h5d);
    do_op(PFBO_OP_RESET, 22'h000000, 8'h00);
    chk(rlow >= RESET_CYC, "reset pulse short");
    chk(busy_seen > 0, "busy not reported");
    do_op(PFBO_OP_READ, 22'h00000c, 8'h00);
    chk(got === 8'h5d, "no read array after reset");
    $display("test reset busy done");
  endtask

  task automatic t_boost;
    @(posedge clk_sys);
    boost_en <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(program_boost_pin === 1'b1, "boost pin not raised");
    do_op(PFBO_OP_WRITE, 22'h00000a, 8'h11);
    @(posedge clk_sys);
    boost_en <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(program_boost_pin === 1'b0, "boost pin stuck");
    $display("test boost done");
  endtask

  initial
  begin
    {reset, req_valid, boost_en, req_addr, req_wdata} = {3'b100, 30'h0};
    req_op = PFBO_OP_READ;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_idle;
    t_read_array;
    t_write_read;
    t_bypass;
    t_protect;
    t_reset_busy;
    t_boost;
    close_out;
  end

  // about 160 cycles are expected; far beyond that something hangs
  initial
  begin
    #(50 * 5000);
    miscompares++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    close_out;
  end
endmodule
`default_nettype wire
